// file: design/usart_cfg_defines.vh
`ifndef USART_CFG_DEFINES_VH
`define USART_CFG_DEFINES_VH
// Register indices (byte address is four times the index)
`define IDX_FRAME_FMT 5'h07
`define IDX_BAUD_LO 5'h08
`define IDX_BAUD_HI 5'h09
`define IDX_SYNC_TOL 5'h0a
`define IDX_HALT_CTL 5'h0b
`define IDX_IR_EVT 5'h0c
`define IDX_IR_PULSE 5'h0d
`define IDX_STATUS 5'h10
// Reset values
`define RST_FRAME_FMT 8'h03
`define RST_BAUD 16'h0000
`define RST_BYTE 8'h00
// Frame format field positions
`define FMT_MODE_HI 7
`define FMT_MODE_LO 6
`define FMT_PAR_HI 5
`define FMT_PAR_LO 4
`define FMT_STOP 3
`define FMT_WID_HI 2
`define FMT_WID_LO 0
`define FMT_SPI_ORDER 2
`define FMT_SPI_PHASE 1
// Other field positions
`define TOL_HI 7
`define TOL_LO 6
`define HALT_RUN 0
`define IR_EVT_EN 0
`define ST_PARITY_ERROR_FLAG 0
`define ST_HALTED 1
// Communication modes
`define MODE_ASYNC 2'h0
`define MODE_SYNC 2'h1
`define MODE_IR 2'h2
`define MODE_SPI 2'h3
// Parity codes
`define PAR_OFF 2'h0
`define PAR_RSVD 2'h1
`define PAR_EVEN 2'h2
`define PAR_ODD 2'h3
// Character width codes
`define WID_5 3'h0
`define WID_6 3'h1
`define WID_7 3'h2
`define WID_8 3'h3
`define WID_9L 3'h6
`define WID_9H 3'h7
// Infrared pulse codes and timing
`define IR_PULSE_3_16 8'h00
`define IR_PULSE_BYPASS 8'hff
`define IR_SAMPLES_PER_BIT 4'hf
`define IR_3_16_SAMPLES 4'h3
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: design/usart_frame_and_ir_config.v
`timescale 1ns/1ps
`include "usart_cfg_defines.vh"

module usart_frame_and_ir_config #(
  parameter ADDR_W = 7
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Debug halt from the processor, same clock
  input wire debug_halt,
  // Serial line side
  input wire rx_pin,
  input wire rx_event,
  input wire tx_line,
  output wire ir_tx_out,
  output wire rx_to_core,
  // Receiver parity check strobe, same clock
  input wire chk_valid,
  input wire [8:0] chk_data,
  input wire chk_parity,
  // Decoded configuration for the shift engines
  output wire [1:0] comm_mode_select,
  output wire parity_enable,
  output wire parity_odd,
  output wire two_stop_bits,
  output wire [3:0] data_bits,
  output wire nine_bit_high_first,
  output wire spi_bit_order,
  output wire spi_sample_phase,
  output wire [1:0] sync_tolerance_window,
  output wire baud_tick,
  output wire port_halted,
  output wire parity_error_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg awready_ff; // Write address slot free
  reg wready_ff; // Write data slot free
  reg aw_held_ff; // Write address captured
  reg w_held_ff; // Write data captured
  reg [4:0] aw_idx_ff; // Captured word index
  reg aw_bad_ff; // Captured address not word aligned
  reg [7:0] w_byte_ff; // Captured low data byte
  reg w_lane_ff; // Low lane strobe captured
  reg bvalid_ff; // Write response pending
  reg [1:0] bresp_ff; // Write response code
  reg arready_ff; // Read address slot free
  reg rvalid_ff; // Read data pending
  reg [31:0] rdata_ff; // Read data word
  reg [1:0] rresp_ff; // Read response code
  reg [7:0] fmt_ff; // Frame format / host SPI format control
  reg [15:0] baud_ff; // Bit rate divisor
  reg [1:0] tol_ff; // Sync tolerance window
  reg run_ff; // Run while halted
  reg ir_ev_ff; // Infrared event input enable
  reg [7:0] ir_pw_ff; // Infrared pulse width
  reg parity_error_flag_ff; // Parity error flag
  reg halted_ff; // Port halted by debug
  reg [15:0] pre_ff; // Baud prescaler count
  reg tick_ff; // Baud sample tick
  reg [3:0] samp_ff; // Samples within a bit period
  reg [7:0] fix_ff; // Fixed pulse clocks left
  reg ir_out_ff; // Infrared transmit output
  reg pin_s1_ff; // Receive pin synchroniser stage one
  reg pin_s2_ff; // Receive pin synchroniser stage two
  reg ev_s1_ff; // Event synchroniser stage one
  reg ev_s2_ff; // Event synchroniser stage two
  reg ev_hold_ff; // Event level kept while halted
  reg rx_out_ff; // Selected receive line
  reg [1:0] mode_o_ff; // Registered decoded outputs
  reg par_en_o_ff;
  reg par_odd_o_ff;
  reg stop2_o_ff;
  reg [3:0] bits_o_ff;
  reg nine_hi_o_ff;
  reg order_o_ff;
  reg phase_o_ff;
  reg [1:0] tol_o_ff;

  wire [1:0] mode; // Current communication mode
  wire spi_mode; // Host SPI layout active
  wire ir_mode; // Infrared mode active
  wire do_write; // Both write halves present
  wire wr_en; // Write lands in a register
  wire par_en; // Parity active after reserved mapping
  reg [3:0] nxt_bits; // Data bit count from width code
  reg [31:0] nxt_rdata; // Read mux result
  reg nxt_rd_ok; // Read index mapped
  reg [8:0] chk_mask; // Data bits covered by parity
  wire chk_par; // Parity computed over received bits
  wire exp_par; // Expected parity bit
  wire pulse_on; // Infrared pulse active this clock
  wire bit_start; // First sample of a bit period
  wire rx_sel; // Receive source after selection

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  assign mode = fmt_ff[`FMT_MODE_HI:`FMT_MODE_LO];
  assign spi_mode = (mode == `MODE_SPI);
  assign ir_mode = (mode == `MODE_IR);
  // Reserved parity code behaves as disabled
  assign par_en = ~spi_mode &&
    (fmt_ff[`FMT_PAR_HI:`FMT_PAR_LO] == `PAR_EVEN ||
     fmt_ff[`FMT_PAR_HI:`FMT_PAR_LO] == `PAR_ODD);

  // Character width to data bit count; reserved codes give eight
  always @* begin
    case (fmt_ff[`FMT_WID_HI:`FMT_WID_LO])
      `WID_5: nxt_bits = 4'h5;
      `WID_6: nxt_bits = 4'h6;
      `WID_7: nxt_bits = 4'h7;
      `WID_9L: nxt_bits = 4'h9;
      `WID_9H: nxt_bits = 4'h9;
      default: nxt_bits = 4'h8;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_en = do_write && w_lane_ff && !aw_bad_ff;

  // Address and data are taken independently, response follows both
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 5'h00;
      aw_bad_ff <= 1'b0;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      // Capture write address
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
        aw_idx_ff <= s_axi_awaddr[6:2];
        aw_bad_ff <= (s_axi_awaddr[1:0] != 2'h0);
      end
      // Capture write data, low byte lane only
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      // Perform write and raise response
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        case (aw_idx_ff)
          `IDX_FRAME_FMT, `IDX_BAUD_LO, `IDX_BAUD_HI, `IDX_SYNC_TOL,
          `IDX_HALT_CTL, `IDX_IR_EVT, `IDX_IR_PULSE, `IDX_STATUS:
            bresp_ff <= aw_bad_ff ? `RESP_SLVERR : `RESP_OKAY;
          default: bresp_ff <= `RESP_SLVERR;
        endcase
      end
      // Response taken, slots reopen
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fmt_ff <= `RST_FRAME_FMT;
      baud_ff <= `RST_BAUD;
      tol_ff <= 2'h0;
      run_ff <= 1'b0;
      ir_ev_ff <= 1'b0;
      ir_pw_ff <= `RST_BYTE;
    end else if (wr_en) begin
      case (aw_idx_ff)
        // All eight bits kept; layout read back depends on mode
        `IDX_FRAME_FMT: fmt_ff <= w_byte_ff;
        `IDX_BAUD_LO: baud_ff[7:0] <= w_byte_ff;
        `IDX_BAUD_HI: baud_ff[15:8] <= w_byte_ff;
        `IDX_SYNC_TOL: tol_ff <= w_byte_ff[`TOL_HI:`TOL_LO];
        `IDX_HALT_CTL: run_ff <= w_byte_ff[`HALT_RUN];
        `IDX_IR_EVT: ir_ev_ff <= w_byte_ff[`IR_EVT_EN];
        `IDX_IR_PULSE: ir_pw_ff <= w_byte_ff;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rd_ok = (s_axi_araddr[1:0] == 2'h0);
    case (s_axi_araddr[6:2])
      `IDX_FRAME_FMT:
        if (spi_mode)
          nxt_rdata[7:0] = {fmt_ff[7:6], 3'h0, fmt_ff[2:1], 1'b0};
        else
          nxt_rdata[7:0] = fmt_ff;
      `IDX_BAUD_LO: nxt_rdata[7:0] = baud_ff[7:0];
      `IDX_BAUD_HI: nxt_rdata[7:0] = baud_ff[15:8];
      `IDX_SYNC_TOL: nxt_rdata[7:0] = {tol_ff, 6'h00};
      `IDX_HALT_CTL: nxt_rdata[7:0] = {7'h00, run_ff};
      `IDX_IR_EVT: nxt_rdata[7:0] = {7'h00, ir_ev_ff};
      `IDX_IR_PULSE: nxt_rdata[7:0] = ir_pw_ff;
      `IDX_STATUS: nxt_rdata[7:0] = {6'h00, halted_ff, parity_error_flag_ff};
      default: nxt_rd_ok = 1'b0;
    endcase
  end

  // One read at a time, data one cycle after address is taken
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rd_ok ? nxt_rdata : 32'h0000_0000;
        rresp_ff <= nxt_rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver parity check
  always @* begin
    case (nxt_bits)
      4'h5: chk_mask = 9'h01f;
      4'h6: chk_mask = 9'h03f;
      4'h7: chk_mask = 9'h07f;
      4'h9: chk_mask = 9'h1ff;
      default: chk_mask = 9'h0ff;
    endcase
  end
  assign chk_par = ^(chk_data & chk_mask);
  // Odd parity bit makes the total count odd
  assign exp_par = chk_par ^
    (fmt_ff[`FMT_PAR_HI:`FMT_PAR_LO] == `PAR_ODD);

  // Sticky flag; a new mismatch wins over a clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parity_error_flag_ff <= 1'b0;
    end else if (chk_valid && par_en && !halted_ff &&
                 (chk_parity != exp_par)) begin
      parity_error_flag_ff <= 1'b1;
    end else if (wr_en && aw_idx_ff == `IDX_STATUS &&
                 w_byte_ff[`ST_PARITY_ERROR_FLAG]) begin
      parity_error_flag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debug halt and baud prescaler
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      halted_ff <= 1'b0;
      pre_ff <= 16'h0000;
      tick_ff <= 1'b0;
      samp_ff <= 4'h0;
    end else begin
      halted_ff <= debug_halt && !run_ff;
      tick_ff <= 1'b0;
      if (wr_en && (aw_idx_ff == `IDX_BAUD_LO ||
                    aw_idx_ff == `IDX_BAUD_HI)) begin
        // Immediate reload; a frame in flight may be corrupted
        pre_ff <= 16'h0000;
        samp_ff <= 4'h0;
      end else if (!halted_ff) begin
        if (pre_ff >= baud_ff) begin
          pre_ff <= 16'h0000;
          tick_ff <= 1'b1;
          samp_ff <= samp_ff + 4'h1;
        end else begin
          pre_ff <= pre_ff + 16'h0001;
        end
      end
    end
  end
  assign bit_start = tick_ff && (samp_ff == 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // Infrared transmit pulse shaping
  // A zero bit is sent as a short low pulse, a one bit as idle high
  assign pulse_on = (ir_pw_ff == `IR_PULSE_3_16) ?
    (samp_ff >= 4'h1 && samp_ff <= `IR_3_16_SAMPLES) :
    (fix_ff != 8'h00);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fix_ff <= 8'h00;
      ir_out_ff <= 1'b1;
    end else begin
      // Fixed pulse begins on the baud clock rising edge
      if (bit_start && !tx_line)
        fix_ff <= ir_pw_ff;
      else if (fix_ff != 8'h00)
        fix_ff <= fix_ff - 8'h01;
      // Coding only in infrared mode and never in bypass
      if (!ir_mode || ir_pw_ff == `IR_PULSE_BYPASS)
        ir_out_ff <= tx_line;
      else
        ir_out_ff <= !(pulse_on && !tx_line);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive source selection
  assign rx_sel = (ir_mode && ir_ev_ff) ? ev_hold_ff : pin_s2_ff;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      ev_s1_ff <= 1'b1;
      ev_s2_ff <= 1'b1;
      ev_hold_ff <= 1'b1;
      rx_out_ff <= 1'b1;
    end else begin
      pin_s1_ff <= rx_pin;
      pin_s2_ff <= pin_s1_ff;
      ev_s1_ff <= rx_event;
      ev_s2_ff <= ev_s1_ff;
      // Events are ignored while halted
      if (!halted_ff)
        ev_hold_ff <= ev_s2_ff;
      rx_out_ff <= rx_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered configuration outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_o_ff <= `MODE_ASYNC;
      par_en_o_ff <= 1'b0;
      par_odd_o_ff <= 1'b0;
      stop2_o_ff <= 1'b0;
      bits_o_ff <= 4'h8;
      nine_hi_o_ff <= 1'b0;
      order_o_ff <= 1'b0;
      phase_o_ff <= 1'b0;
      tol_o_ff <= 2'h0;
    end else begin
      mode_o_ff <= mode;
      par_en_o_ff <= par_en;
      // Odd only when parity is live; the field is gone in host SPI
      par_odd_o_ff <= par_en &&
        fmt_ff[`FMT_PAR_HI:`FMT_PAR_LO] == `PAR_ODD;
      // Stop count is for the transmitter only
      stop2_o_ff <= !spi_mode && fmt_ff[`FMT_STOP];
      bits_o_ff <= spi_mode ? 4'h8 : nxt_bits;
      nine_hi_o_ff <= !spi_mode &&
        fmt_ff[`FMT_WID_HI:`FMT_WID_LO] == `WID_9H;
      order_o_ff <= spi_mode && fmt_ff[`FMT_SPI_ORDER];
      phase_o_ff <= spi_mode && fmt_ff[`FMT_SPI_PHASE];
      tol_o_ff <= tol_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output connections
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign ir_tx_out = ir_out_ff;
  assign rx_to_core = rx_out_ff;
  assign comm_mode_select = mode_o_ff;
  assign parity_enable = par_en_o_ff;
  assign parity_odd = par_odd_o_ff;
  assign two_stop_bits = stop2_o_ff;
  assign data_bits = bits_o_ff;
  assign nine_bit_high_first = nine_hi_o_ff;
  assign spi_bit_order = order_o_ff;
  assign spi_sample_phase = phase_o_ff;
  assign sync_tolerance_window = tol_o_ff;
  assign baud_tick = tick_ff;
  assign port_halted = halted_ff;
  assign parity_error_flag = parity_error_flag_ff;

endmodule // usart_frame_and_ir_config

// file: sim/far_end_line.sv
`timescale 1ns/1ps
module far_end_line (
  // Clock
  input wire clock,
  // Levels asked for by the bench
  input wire pin_level,
  input wire evt_level,
  // Lines into the port
  output reg rx_pin = 1'b1,
  output reg rx_event = 1'b0
);
  // Pin idles high; both lines move just after an edge
  always @(posedge clock) begin
    rx_pin <= pin_level;
    rx_event <= evt_level;
  end
endmodule // far_end_line

// file: sim/tb_usart_frame_and_ir_config.sv
`timescale 1ns/1ps
`include "usart_cfg_defines.vh"
module tb_usart_frame_and_ir_config;
  // Drive side
  reg clock = 1'b0, rst_n = 1'b0;
  reg [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, debug_halt = 1'b0;
  reg tx_line = 1'b1, chk_valid = 1'b0, chk_parity = 1'b0;
  reg pin_level = 1'b1, evt_level = 1'b0, busy;
  reg [8:0] chk_data = 9'h000;
  // Observed side
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, rx_pin, rx_event, ir_tx_out, rx_to_core;
  wire parity_enable, parity_odd, two_stop_bits, nine_bit_high_first;
  wire spi_bit_order, spi_sample_phase, baud_tick, port_halted;
  wire parity_error_flag;
  wire [1:0] s_axi_bresp, s_axi_rresp, comm_mode_select;
  wire [1:0] sync_tolerance_window;
  wire [31:0] s_axi_rdata;
  wire [3:0] data_bits;
  // Results
  integer failures = 0, n_compared = 0, cnt, i;
  reg [1:0] resp;
  reg [31:0] rd;

  // Clock toggles each half period
  always #2.5 clock = ~clock;

  usart_frame_and_ir_config usart_frame_and_ir_config_i (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .debug_halt, .rx_pin, .rx_event, .tx_line, .ir_tx_out, .rx_to_core,
    .chk_valid, .chk_data, .chk_parity, .comm_mode_select, .parity_enable,
    .parity_odd, .two_stop_bits, .data_bits, .nine_bit_high_first,
    .spi_bit_order, .spi_sample_phase, .sync_tolerance_window, .baud_tick,
    .port_halted, .parity_error_flag);
  far_end_line far_end_line_i (
    .clock, .pin_level, .evt_level, .rx_pin, .rx_event);

  ////////////////////////////////////////////////////////////////////////
  // Compare and close
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (failures == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master: write, each half released when taken
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      busy = 1'b1;
      while (busy) begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          s_axi_bready <= 1'b0;
          resp = s_axi_bresp;
          busy = 1'b0;
        end
      end
    end
  endtask
  // Bus master: read
  task rdreg(input [6:0] a);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      busy = 1'b1;
      while (busy) begin
        @(posedge clock);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          s_axi_rready <= 1'b0;
          rd = s_axi_rdata;
          resp = s_axi_rresp;
          busy = 1'b0;
        end
      end
    end
  endtask
  // Cycles until the next baud tick
  task meas;
    begin
      cnt = 0;
      do begin
        @(posedge clock);
        cnt = cnt + 1;
      end while (!baud_tick && cnt < 2000);
    end
  endtask
  // Low cycles of the infrared output over 64 clocks
  task lows;
    begin
      cnt = 0;
      repeat (64) begin
        @(posedge clock);
        cnt = cnt + (ir_tx_out ? 0 : 1);
      end
    end
  endtask
  // One receiver parity check strobe
  task pchk(input [8:0] d, input p);
    begin
      @(posedge clock);
      chk_data <= d;
      chk_parity <= p;
      chk_valid <= 1'b1;
      @(posedge clock);
      chk_valid <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset_and_map;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        rdreg(7'h1c + {i[4:0], 2'b00});
        chk(rd, (i == 0) ? 32'h3 : 32'h0);
      end
      chk({28'h0, data_bits}, 32'h8);
      rdreg(7'h3c);
      chk({22'h0, resp, rd[7:0]}, {22'h0, `RESP_SLVERR, 8'h00});
      wr(7'h1d, 8'h00);
      chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    end
  endtask
  task t_frame;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(7'h1c, 8'h28 | i[7:0]);
        repeat (2) @(posedge clock);
        chk({28'h0, data_bits}, i < 4 ? i + 5 : (i < 6 ? 8 : 9));
        chk({31'h0, nine_bit_high_first}, i == 7);
        chk({two_stop_bits, parity_enable, parity_odd}, 3'b110);
      end
      for (i = 0; i < 4; i = i + 1) begin
        wr(7'h1c, {2'b00, i[1:0], 4'b0011});
        repeat (2) @(posedge clock);
        chk({parity_enable, parity_odd}, {i > 1, i == 3});
      end
      for (i = 0; i < 4; i = i + 1) begin
        wr(7'h1c, {i[1:0], 6'h3e});
        rdreg(7'h1c);
        chk(rd, i == 3 ? 32'hc6 : {24'h0, i[1:0], 6'h3e});
        chk({30'h0, comm_mode_select}, i);
      end
      chk({two_stop_bits, spi_bit_order, spi_sample_phase}, 3'b011);
      wr(7'h1c, 8'hc2);
      repeat (2) @(posedge clock);
      chk({spi_bit_order, spi_sample_phase}, 2'b01);
    end
  endtask
  task t_baud;
    begin
      wr(7'h24, 8'h01);
      wr(7'h20, 8'h05);
      rdreg(7'h24);
      chk(rd, 32'h01);
      meas;
      meas;
      chk(cnt, 262);
      wr(7'h24, 8'h00);
      meas;
      chk(cnt <= 6, 1);
      meas;
      chk(cnt, 6);
      for (i = 0; i < 4; i = i + 1) begin
        wr(7'h28, {i[1:0], 6'h00});
        repeat (2) @(posedge clock);
        chk({30'h0, sync_tolerance_window}, i);
      end
    end
  endtask
  task t_halt_parity;
    begin
      wr(7'h1c, 8'h23);
      pchk(9'h003, 1'b1);
      chk(parity_error_flag, 1);
      wr(7'h40, 8'h01);
      pchk(9'h007, 1'b1);
      chk(parity_error_flag, 0);
      wr(7'h1c, 8'h33);
      pchk(9'h007, 1'b1);
      chk(parity_error_flag, 1);
      wr(7'h40, 8'h01);
      wr(7'h1c, 8'h20);
      pchk(9'h1e0, 1'b0);
      wr(7'h1c, 8'h13);
      pchk(9'h003, 1'b1);
      chk(parity_error_flag, 0);
      debug_halt <= 1'b1;
      repeat (3) @(posedge clock);
      chk(port_halted, 1);
      rdreg(7'h40);
      chk(rd, 32'h2);
      wr(7'h2c, 8'h01);
      repeat (3) @(posedge clock);
      chk(port_halted, 0);
      debug_halt <= 1'b0;
    end
  endtask
  task t_infrared;
    begin
      wr(7'h20, 8'h01);
      wr(7'h34, 8'hff);
      wr(7'h1c, 8'h83);
      tx_line <= 1'b0;
      repeat (3) @(posedge clock);
      chk(ir_tx_out, 0);
      wr(7'h34, 8'h04);
      repeat (40) @(posedge clock);
      lows;
      chk(cnt, 8);
      wr(7'h34, 8'h00);
      repeat (40) @(posedge clock);
      lows;
      chk(cnt, 12);
      pin_level <= 1'b1;
      wr(7'h30, 8'h01);
      repeat (6) @(posedge clock);
      chk(rx_to_core, 0);
      evt_level <= 1'b1;
      pin_level <= 1'b0;
      repeat (6) @(posedge clock);
      chk(rx_to_core, 1);
      wr(7'h1c, 8'h03);
      lows;
      chk(cnt, 64);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset_and_map;
    t_frame;
    t_baud;
    t_halt_parity;
    t_infrared;
    complete_run;
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge clock);
    failures = failures + 1;
    complete_run;
  end
endmodule // tb_usart_frame_and_ir_config

// file: sim/usart_cfg_props.sv
`timescale 1ns/1ps
`include "usart_cfg_defines.vh"
module usart_cfg_props (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Bus answers
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Line side
  input wire debug_halt,
  input wire rx_pin,
  input wire tx_line,
  input wire ir_tx_out,
  input wire rx_to_core,
  // Parity check strobe
  input wire chk_valid,
  input wire [8:0] chk_data,
  input wire chk_parity,
  // Decoded configuration
  input wire [1:0] comm_mode_select,
  input wire parity_enable,
  input wire parity_odd,
  input wire two_stop_bits,
  input wire [3:0] data_bits,
  input wire nine_bit_high_first,
  input wire port_halted,
  input wire parity_error_flag
);
  // Parity of the active data bits, inverted for odd
  function automatic logic exp_par(input [8:0] d, input [3:0] n,
                                   input odd);
    exp_par = ^(d & (9'h1ff >> (4'd9 - n))) ^ odd;
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Bus answers stand until taken
  sequence s_bwait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
  property p_bresp_stands;
    s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_stands: assert property (p_bresp_stands)
    else $error("write response dropped early");
  property p_rdata_stands;
    s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data dropped early");

  ////////////////////////////////////////////////////////////////////////
  // Field decoding
  property p_spi_layout;
    comm_mode_select == `MODE_SPI |-> !two_stop_bits;
  endproperty
  a_spi_layout: assert property (p_spi_layout)
    else $error("stop setting seen in host spi mode");
  property p_parity_code;
    parity_odd |-> parity_enable;
  endproperty
  a_parity_code: assert property (p_parity_code)
    else $error("odd parity without parity enabled");
  property p_nine_width;
    nine_bit_high_first |-> data_bits == 4'd9;
  endproperty
  a_nine_width: assert property (p_nine_width)
    else $error("nine bit order with other width");

  ////////////////////////////////////////////////////////////////////////
  // Parity checking
  sequence s_bad_char;
    chk_valid && parity_enable && !port_halted &&
    (chk_parity != exp_par(chk_data, data_bits, parity_odd));
  endsequence
  property p_parity_error_flag_set;
    s_bad_char |=> parity_error_flag;
  endproperty
  a_parity_error_flag_set: assert property (p_parity_error_flag_set)
    else $error("parity mismatch not flagged");
  property p_parity_error_flag_cause;
    $rose(parity_error_flag) |-> $past(chk_valid);
  endproperty
  a_parity_error_flag_cause: assert property (p_parity_error_flag_cause)
    else $error("parity flag set without a check");

  ////////////////////////////////////////////////////////////////////////
  // Halt and line paths
  property p_halt_cause;
    port_halted |-> $past(debug_halt);
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("port halted without debug halt");
  sequence s_plain_mode; (comm_mode_select != `MODE_IR) [*2]; endsequence
  property p_tx_pass;
    s_plain_mode ##0 $past(rst_n) |-> ir_tx_out == $past(tx_line);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("transmit line altered outside infrared");
  sequence s_pin_path; (comm_mode_select != `MODE_IR) [*4]; endsequence
  property p_rx_pin;
    s_pin_path ##0 $past(rst_n, 4) |-> rx_to_core == $past(rx_pin, 3);
  endproperty
  a_rx_pin: assert property (p_rx_pin)
    else $error("receive path not from pin");
endmodule // usart_cfg_props

bind usart_frame_and_ir_config usart_cfg_props usart_cfg_props_i (
  .clock, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .debug_halt, .rx_pin,
  .tx_line, .ir_tx_out, .rx_to_core, .chk_valid, .chk_data, .chk_parity,
  .comm_mode_select, .parity_enable, .parity_odd, .two_stop_bits,
  .data_bits, .nine_bit_high_first, .port_halted, .parity_error_flag);
